// file: src/pin_port_map.vh
// Offsets, field positions, reset values and timing counts of the pin port
`ifndef PIN_PORT_MAP_VH
`define PIN_PORT_MAP_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define PP_CTRL_OFF 8'h00
`define PP_TXDATA_OFF 8'h04
`define PP_STATUS_OFF 8'h08
`define PP_HADDR_OFF 8'h0c
`define PP_WIN_BASE 8'h20

// ************************************************************
// Control fields
// ************************************************************
`define PP_CTRL_BACKPLANE 0
`define PP_CTRL_OPEN_DRAIN 1
`define PP_CTRL_STYLE68 2
`define PP_CTRL_IRQ 3
`define PP_CTRL_RST 4'h0

// ************************************************************
// Status fields
// ************************************************************
`define PP_ST_TX_BUSY 0
`define PP_ST_MUX 1
`define PP_ST_FAST 2
`define PP_ST_POL_HIGH 3
`define PP_ST_RX_LEVEL 4
`define PP_ST_RX_SEEN 5
`define PP_ST_HOST_WR 6
`define PP_ST_HOST_RST 7

// ************************************************************
// Timing
// ************************************************************
`define PP_CLK_NS 5
`define PP_BIT_NS 3200
`define PP_PULSE_NS 100
`define PP_BIT_CYC ((`PP_BIT_NS) / (`PP_CLK_NS))
`define PP_PULSE_CYC (((`PP_PULSE_NS) + (`PP_CLK_NS) - 1) / (`PP_CLK_NS))
`define PP_STRAP_WAIT 3'h6

// ************************************************************
// Bus answers
// ************************************************************
`define PP_RESP_OKAY 2'b00
`define PP_RESP_SLVERR 2'b10

`endif

// file: src/pin_sync3.v
// Three-stage synchroniser bank; a bit changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync3 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Data
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] stable_o
);
    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    s1_reg[g] <= RESET_VAL[g];
                    s2_reg[g] <= RESET_VAL[g];
                    s3_reg[g] <= RESET_VAL[g];
                    stable_o[g] <= RESET_VAL[g];
                end else begin
                    s1_reg[g] <= async_i[g];
                    s2_reg[g] <= s1_reg[g];
                    s3_reg[g] <= s2_reg[g];
                    // A one-cycle glitch never passes both late stages
                    if (s2_reg[g] == s3_reg[g]) begin
                        stable_o[g] <= s3_reg[g];
                    end
                end
            end
        end
    endgenerate
endmodule // pin_sync3
`default_nettype wire

// file: src/line_encoder.v
// Line side transmitter: two-pulse waveform or backplane level plus clock
`timescale 1ns/10ps
`default_nettype none
module line_encoder #(
    parameter BIT_CYC = 640,
    parameter PULSE_CYC = 20
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // Control
    input wire start_i,
    input wire [7:0] data_i,
    input wire backplane_i,
    input wire open_drain_i,
    input wire b_drive_ok_i,
    input wire halt_i,
    output reg busy_o,
    // Pins
    output reg drive_a_n_o,
    output reg drive_a_oe_o,
    output reg drive_b_n_o,
    output reg drive_b_oe_o
);
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_SEND = 2'b10;
    localparam [31:0] LAST_W = BIT_CYC - 1;
    localparam [31:0] QUARTER_W = BIT_CYC / 4;
    localparam [31:0] P1_W = PULSE_CYC;
    localparam [31:0] P2_W = 2 * PULSE_CYC;
    localparam [15:0] LAST_CYC = LAST_W[15:0];
    localparam [15:0] QUARTER = QUARTER_W[15:0];
    localparam [15:0] P1 = P1_W[15:0];
    localparam [15:0] P2 = P2_W[15:0];

    reg [1:0] state_reg;
    reg [15:0] cyc_reg;
    reg [15:0] clk_cnt_reg;
    reg [2:0] bit_reg;
    reg [7:0] shift_reg;
    reg bclk_reg;
    wire cur_bit = shift_reg[0];
    wire sending = (state_reg == ST_SEND);

    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_IDLE;
            cyc_reg <= 16'h0000;
            clk_cnt_reg <= 16'h0000;
            bit_reg <= 3'h0;
            shift_reg <= 8'h00;
            bclk_reg <= 1'b1;
            busy_o <= 1'b0;
            drive_a_n_o <= 1'b1;
            drive_a_oe_o <= 1'b0;
            drive_b_n_o <= 1'b1;
            drive_b_oe_o <= 1'b0;
        end else begin
            // Free clock at twice the bit rate: toggles every quarter bit
            if (clk_cnt_reg >= QUARTER - 16'h0001) begin
                clk_cnt_reg <= 16'h0000;
                bclk_reg <= ~bclk_reg;
            end else begin
                clk_cnt_reg <= clk_cnt_reg + 16'h0001;
            end
            case (state_reg)
                ST_IDLE: begin
                    cyc_reg <= 16'h0000;
                    bit_reg <= 3'h0;
                    if (start_i && !halt_i) begin
                        shift_reg <= data_i;
                        state_reg <= ST_SEND;
                        busy_o <= 1'b1;
                    end
                end
                ST_SEND: begin
                    if (halt_i) begin
                        state_reg <= ST_IDLE;
                        busy_o <= 1'b0;
                    end else if (cyc_reg == LAST_CYC) begin
                        cyc_reg <= 16'h0000;
                        shift_reg <= {1'b0, shift_reg[7:1]};
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_reg <= ST_IDLE;
                            busy_o <= 1'b0;
                        end
                    end else begin
                        cyc_reg <= cyc_reg + 16'h0001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_o <= 1'b0;
                end
            endcase
            if (backplane_i) begin
                // Level on line A, low for a one; open-drain only pulls low
                drive_a_n_o <= ~(sending & cur_bit);
                drive_a_oe_o <= open_drain_i ? (sending & cur_bit) : 1'b1;
                drive_b_n_o <= bclk_reg;
            end else begin
                // A one sends a low pulse on A, then one on B
                drive_a_n_o <= ~(sending & cur_bit & (cyc_reg < P1));
                drive_a_oe_o <= 1'b1;
                drive_b_n_o <= ~(sending & cur_bit & (cyc_reg >= P1) & (cyc_reg < P2));
            end
            // Line B stays released until its strap has been read
            drive_b_oe_o <= b_drive_ok_i;
        end
    end
endmodule // line_encoder
`default_nettype wire

// file: src/pin_port.v
// Host pin port and line driver control of the token network controller
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "pin_port_map.vh"
module pin_port #(
    parameter BIT_CYC = `PP_BIT_CYC,
    parameter PULSE_CYC = `PP_PULSE_CYC
) (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_b_i,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // Host bus pins
    input wire shared_bus_strap_n_i,
    input wire addr_bit_one_i,
    input wire addr2_latch_en_i,
    input wire [2:0] shared_low_lines_i,
    output reg [2:0] shared_low_lines_o,
    output reg [2:0] shared_low_lines_oe_o,
    input wire [4:0] upper_data_lines_i,
    output reg [4:0] upper_data_lines_o,
    output reg [4:0] upper_data_lines_oe_o,
    input wire store_strobe_n_i,
    input wire read_strobe_n_i,
    input wire chip_select_n_i,
    input wire host_reset_n_i,
    input wire access_timing_select_i,
    output reg irq_out_n_o,
    output reg host_pull_up_en_o,
    // Line pins
    output wire line_drive_a_n_o,
    output wire line_drive_a_n_oe_o,
    output reg line_drive_a_pull_en_o,
    input wire line_drive_b_n_i,
    output wire line_drive_b_n_o,
    output wire line_drive_b_n_oe_o,
    input wire line_receive_i,
    output reg driver_on_o
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    wire [17:0] pins_s;
    pin_sync3 #(.WIDTH(18), .RESET_VAL(18'h3ffff)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .async_i({line_drive_b_n_i, line_receive_i, access_timing_select_i, host_reset_n_i,
                  chip_select_n_i, read_strobe_n_i, store_strobe_n_i, upper_data_lines_i,
                  shared_low_lines_i, addr2_latch_en_i, addr_bit_one_i, shared_bus_strap_n_i}),
        .stable_o(pins_s)
    );
    wire a0_s = pins_s[0];
    wire a1_s = pins_s[1];
    wire a2_s = pins_s[2];
    wire [2:0] low_s = pins_s[5:3];
    wire [4:0] up_s = pins_s[10:6];
    wire wr_s = pins_s[11];
    wire rd_s = pins_s[12];
    wire cs_n_s = pins_s[13];
    wire hrst_n_s = pins_s[14];
    wire tmg_s = pins_s[15];
    wire rx_s = pins_s[16];
    wire b_s = pins_s[17];

    // ************************************************************
    // State
    // ************************************************************
    reg [3:0] ctrl_reg;
    reg [7:0] txdata_reg;
    reg tx_start_reg;
    reg [7:0] win_reg [0:7];
    reg [2:0] strap_cnt_reg;
    reg strap_done_reg;
    reg mux_mode_reg;
    reg pol_high_reg;
    reg [2:0] ale_addr_reg;
    reg [2:0] wr_addr_reg;
    reg [7:0] wr_data_reg;
    reg wr_prev_reg;
    reg rx_prev_reg;
    reg rx_seen_reg;
    reg host_wr_seen_reg;
    reg [2:0] last_addr_reg;
    reg aw_held_reg;
    reg w_held_reg;
    reg [7:0] aw_addr_reg;
    reg [7:0] w_data_reg;
    reg w_strb0_reg;
    wire tx_busy;
    integer i;

    // ************************************************************
    // Host bus decode
    // ************************************************************
    wire host_rst = ~hrst_n_s;
    wire style68 = ctrl_reg[`PP_CTRL_STYLE68];
    wire sel_ok = ~cs_n_s & ~host_rst & strap_done_reg;
    // 68xx: store pin is direction, read pin is data strobe
    wire wr_act = style68 ? (sel_ok & ~rd_s & ~wr_s) : (sel_ok & ~wr_s);
    wire rd_act = style68 ? (sel_ok & ~rd_s & wr_s) : (sel_ok & ~rd_s);
    // Fast timing is refused on the multiplexed bus
    wire fast = ~tmg_s & ~mux_mode_reg;
    wire [2:0] host_addr = mux_mode_reg ? ale_addr_reg : {a2_s, a1_s, a0_s};
    wire [7:0] host_data = {up_s, low_s};
    wire wr_rise = wr_act & ~wr_prev_reg;
    wire wr_fall = ~wr_act & wr_prev_reg;
    // Fast mode stores at strobe start; normal mode at strobe end with held data
    wire host_commit = fast ? wr_rise : wr_fall;
    wire [2:0] commit_addr = fast ? host_addr : wr_addr_reg;
    wire [7:0] commit_data = fast ? host_data : wr_data_reg;

    // ************************************************************
    // Bus slave decode
    // ************************************************************
    wire axi_wr = aw_held_reg & w_held_reg & ~s_axi_bvalid_o;
    wire [7:0] status_val = {host_rst, host_wr_seen_reg, rx_seen_reg, rx_s,
                             pol_high_reg, fast, mux_mode_reg, tx_busy};

    function wr_hit;
        input [7:0] addr;
        begin
            wr_hit = (addr == `PP_CTRL_OFF) || (addr == `PP_TXDATA_OFF) ||
                     (addr == `PP_STATUS_OFF) || (addr == `PP_HADDR_OFF) ||
                     ((addr & 8'he3) == `PP_WIN_BASE);
        end
    endfunction

    function is_win;
        input [7:0] addr;
        begin
            is_win = ((addr & 8'he3) == `PP_WIN_BASE);
        end
    endfunction

    // ************************************************************
    // Straps, host access and register file
    // ************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strap_cnt_reg <= 3'h0;
            strap_done_reg <= 1'b0;
            mux_mode_reg <= 1'b0;
            pol_high_reg <= 1'b0;
            ale_addr_reg <= 3'h0;
            wr_addr_reg <= 3'h0;
            wr_data_reg <= 8'h00;
            wr_prev_reg <= 1'b0;
            rx_prev_reg <= 1'b1;
            rx_seen_reg <= 1'b0;
            host_wr_seen_reg <= 1'b0;
            last_addr_reg <= 3'h0;
            ctrl_reg <= `PP_CTRL_RST;
            txdata_reg <= 8'h00;
            tx_start_reg <= 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                win_reg[i] <= 8'h00;
            end
        end else begin
            // Straps are read once the synchronisers have settled after release
            if (!strap_done_reg) begin
                strap_cnt_reg <= strap_cnt_reg + 3'h1;
                if (strap_cnt_reg == `PP_STRAP_WAIT) begin
                    strap_done_reg <= 1'b1;
                    mux_mode_reg <= ~a0_s;
                    pol_high_reg <= ~b_s;
                end
            end
            // Address follows the latch enable and holds after it falls
            if (mux_mode_reg && a2_s) begin
                ale_addr_reg <= low_s;
            end
            wr_prev_reg <= wr_act;
            if (wr_act) begin
                wr_addr_reg <= host_addr;
                wr_data_reg <= host_data;
            end
            if (wr_act || rd_act) begin
                last_addr_reg <= host_addr;
            end
            rx_prev_reg <= rx_s;
            tx_start_reg <= 1'b0;
            if (axi_wr && w_strb0_reg) begin
                case (aw_addr_reg)
                    `PP_CTRL_OFF: ctrl_reg <= w_data_reg[3:0];
                    `PP_TXDATA_OFF: begin
                        txdata_reg <= w_data_reg;
                        tx_start_reg <= ~tx_busy;
                    end
                    `PP_STATUS_OFF: begin
                        if (w_data_reg[`PP_ST_RX_SEEN]) rx_seen_reg <= 1'b0;
                        if (w_data_reg[`PP_ST_HOST_WR]) host_wr_seen_reg <= 1'b0;
                    end
                    default: begin
                        if (is_win(aw_addr_reg)) begin
                            win_reg[aw_addr_reg[4:2]] <= w_data_reg;
                        end
                    end
                endcase
            end
            // Events after the clear so a same-cycle event is kept
            if (rx_s != rx_prev_reg) begin
                rx_seen_reg <= 1'b1;
            end
            if (host_commit) begin
                win_reg[commit_addr] <= commit_data;
                host_wr_seen_reg <= 1'b1;
            end
            if (host_rst) begin
                ctrl_reg[`PP_CTRL_IRQ] <= 1'b0;
                tx_start_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Pin outputs
    // ************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shared_low_lines_o <= 3'h7;
            shared_low_lines_oe_o <= 3'h0;
            upper_data_lines_o <= 5'h1f;
            upper_data_lines_oe_o <= 5'h00;
            irq_out_n_o <= 1'b1;
            host_pull_up_en_o <= 1'b0;
            line_drive_a_pull_en_o <= 1'b0;
            driver_on_o <= 1'b1;
        end else begin
            shared_low_lines_o <= win_reg[host_addr][2:0];
            upper_data_lines_o <= win_reg[host_addr][7:3];
            shared_low_lines_oe_o <= {3{rd_act}};
            upper_data_lines_oe_o <= {5{rd_act}};
            irq_out_n_o <= ~ctrl_reg[`PP_CTRL_IRQ];
            // Weak pull-ups on bit one, data and timing select
            host_pull_up_en_o <= 1'b1;
            line_drive_a_pull_en_o <= ctrl_reg[`PP_CTRL_BACKPLANE] & ctrl_reg[`PP_CTRL_OPEN_DRAIN];
            // Polarity unknown before the strap reads as the low-active default
            driver_on_o <= pol_high_reg ? tx_busy : ~tx_busy;
        end
    end

    line_encoder #(.BIT_CYC(BIT_CYC), .PULSE_CYC(PULSE_CYC)) u_enc (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .start_i(tx_start_reg),
        .data_i(txdata_reg),
        .backplane_i(ctrl_reg[`PP_CTRL_BACKPLANE]),
        .open_drain_i(ctrl_reg[`PP_CTRL_OPEN_DRAIN]),
        .b_drive_ok_i(strap_done_reg),
        .halt_i(host_rst),
        .busy_o(tx_busy),
        .drive_a_n_o(line_drive_a_n_o),
        .drive_a_oe_o(line_drive_a_n_oe_o),
        .drive_b_n_o(line_drive_b_n_o),
        .drive_b_oe_o(line_drive_b_n_oe_o)
    );

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `PP_RESP_OKAY;
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rresp_o <= `PP_RESP_OKAY;
            s_axi_rdata_o <= 32'h00000000;
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 8'h00;
            w_strb0_reg <= 1'b0;
        end else begin
            s_axi_awready_o <= ~aw_held_reg & ~s_axi_awready_o & s_axi_awvalid_i;
            s_axi_wready_o <= ~w_held_reg & ~s_axi_wready_o & s_axi_wvalid_i;
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i[7:0];
                w_strb0_reg <= s_axi_wstrb_i[0];
            end
            if (axi_wr) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_hit(aw_addr_reg) ? `PP_RESP_OKAY : `PP_RESP_SLVERR;
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
            s_axi_arready_o <= ~s_axi_arready_o & ~s_axi_rvalid_o & s_axi_arvalid_i;
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= wr_hit(s_axi_araddr_i) ? `PP_RESP_OKAY : `PP_RESP_SLVERR;
                case (s_axi_araddr_i)
                    `PP_CTRL_OFF: s_axi_rdata_o <= {28'h0000000, ctrl_reg};
                    `PP_TXDATA_OFF: s_axi_rdata_o <= {24'h000000, txdata_reg};
                    `PP_STATUS_OFF: s_axi_rdata_o <= {24'h000000, status_val};
                    `PP_HADDR_OFF: s_axi_rdata_o <= {29'h0000000, last_addr_reg};
                    default: s_axi_rdata_o <= is_win(s_axi_araddr_i) ?
                        {24'h000000, win_reg[s_axi_araddr_i[4:2]]} : 32'h00000000;
                endcase
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end
endmodule // pin_port
`default_nettype wire

// file: tb/pin_port_monitor.sv
// Port checker for the pin port
`timescale 1ns/10ps
`default_nettype none
module pin_port_monitor (
    // Clock, reset, bus
    input wire logic sys_clk_i, rst_b_i, s_axi_awready_o, s_axi_arvalid_i, s_axi_arready_o,
    input wire logic s_axi_rvalid_o, s_axi_rready_i, s_axi_bvalid_o, s_axi_bready_i,
    input wire logic [31:0] s_axi_rdata_o,
    // Pins
    input wire logic chip_select_n_i, read_strobe_n_i, host_pull_up_en_o,
    input wire logic line_drive_a_n_o, line_drive_a_n_oe_o, line_drive_a_pull_en_o,
    input wire logic [2:0] shared_low_lines_oe_o,
    input wire logic [4:0] upper_data_lines_oe_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_pull; $past(rst_b_i) |-> host_pull_up_en_o; endproperty
    a_pull: assert property (p_pull) else $error("pullup off");
    property p_oe; {upper_data_lines_oe_o, shared_low_lines_oe_o} inside {8'h00, 8'hff}; endproperty
    a_oe: assert property (p_oe) else $error("oe split");
    property p_idle; (chip_select_n_i || read_strobe_n_i) [*8] |=> upper_data_lines_oe_o == 5'h00; endproperty
    a_idle: assert property (p_idle) else $error("stray drive");
    property p_od; line_drive_a_pull_en_o && line_drive_a_n_oe_o |-> !line_drive_a_n_o; endproperty
    a_od: assert property (p_od) else $error("od high");
    property p_aw; s_axi_awready_o |=> !s_axi_awready_o; endproperty
    a_aw: assert property (p_aw) else $error("awready long");
    property p_ar; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o; endproperty
    a_ar: assert property (p_ar) else $error("rvalid late");
    property p_rh; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
    a_rh: assert property (p_rh) else $error("rdata lost");
    property p_bd; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
    a_bd: assert property (p_bd) else $error("bvalid kept");
    c_rd: cover property (s_axi_rvalid_o && s_axi_rready_i);
    c_wr: cover property (s_axi_bvalid_o && s_axi_bready_i);
    c_hrd: cover property (upper_data_lines_oe_o != 5'h00);
endmodule // pin_port_monitor
bind pin_port pin_port_monitor mon_u (.*);
`default_nettype wire

// file: tb/line_xcvr_model.sv
// Line transceiver and board strap model
`timescale 1ns/10ps
`default_nettype none
module line_xcvr_model (
    // Controller line pins, ground strap on line B
    input wire logic a_n_i, a_oe_i, b_n_i, b_oe_i, b_gnd_i,
    // Wires seen by the controller
    output wire logic b_w_o, rx_o
);
    // A ground strap belongs on backplane boards only
    assign b_w_o = b_oe_i ? b_n_i : ~b_gnd_i;
    // Own transmission echoes back; idle line reads high
    assign rx_o = a_oe_i ? a_n_i : 1'b1;
endmodule // line_xcvr_model
`default_nettype wire

// file: tb/pin_port_tb.sv
// Self-checking bench for the pin port
`timescale 1ns/10ps
`default_nettype none
module pin_port_tb;
    logic clk = 0, rst_b = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, cs_n = 1, wr_n = 1, rd_n = 1;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00, hd = 8'hff, hrd;
    logic [31:0] w_d = 32'h0, rd;
    logic [2:0] ha = 3'h7;
    logic hrst_n = 1, tmg = 1;
    logic [1:0] rs;
    int error_cnt = 0, n_checks = 0;
    wire awr, wrr, bv, arr, rv, a_n, a_oe, b_n, b_oe, b_w, rx, drv, irq_n;
    wire [31:0] rdata;
    wire [1:0] rresp, bresp;
    wire [2:0] lo_o, lo_oe;
    wire [4:0] up_o, up_oe;
    wire [7:0] dw = ({up_oe, lo_oe} & {up_o, lo_o}) | (~{up_oe, lo_oe} & hd);
    logic [10:0] rows [3] = '{11'h0a5, 11'h35a, 11'h701};
    always #2.5 clk = ~clk;
    pin_port #(.BIT_CYC(16), .PULSE_CYC(2)) dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .s_axi_awaddr_i(aw_a),
        .s_axi_awvalid_i(aw_v), .s_axi_awready_o(awr), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(w_v), .s_axi_wready_o(wrr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(b_r),
        .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(r_r), .shared_bus_strap_n_i(ha[0]),
        .addr_bit_one_i(ha[1]), .addr2_latch_en_i(ha[2]), .shared_low_lines_i(dw[2:0]), .shared_low_lines_o(lo_o),
        .shared_low_lines_oe_o(lo_oe), .upper_data_lines_i(dw[7:3]), .upper_data_lines_o(up_o),
        .upper_data_lines_oe_o(up_oe), .store_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .chip_select_n_i(cs_n),
        .host_reset_n_i(hrst_n), .access_timing_select_i(tmg), .irq_out_n_o(irq_n), .host_pull_up_en_o(),
        .line_drive_a_n_o(a_n), .line_drive_a_n_oe_o(a_oe), .line_drive_a_pull_en_o(), .line_drive_b_n_i(b_w),
        .line_drive_b_n_o(b_n), .line_drive_b_n_oe_o(b_oe), .line_receive_i(rx), .driver_on_o(drv));
    line_xcvr_model xcvr_u (.a_n_i(a_n), .a_oe_i(a_oe), .b_n_i(b_n), .b_oe_i(b_oe), .b_gnd_i(1'b0),
        .b_w_o(b_w), .rx_o(rx));
    task chk(input string nm, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        aw_a <= a;
        w_d <= d;
        {aw_v, w_v, b_r} <= 3'h7;
        do begin
            @(posedge clk);
            if (awr) aw_v <= 0;
            if (wrr) w_v <= 0;
        end while (!bv);
        rs = bresp;
        b_r <= 0;
        repeat (3) @(posedge clk);
    endtask
    task axr(input logic [7:0] a);
        ar_a <= a;
        {ar_v, r_r} <= 2'h3;
        do begin
            @(posedge clk);
            if (arr) ar_v <= 0;
        end while (!rv);
        rd = rdata;
        rs = rresp;
        r_r <= 0;
        @(posedge clk);
    endtask
    // Strobes stay at each level long enough for the input filter
    task hbus(input logic rdo, cs, input logic [2:0] a, input logic [7:0] d);
        cs_n <= cs;
        ha <= a;
        hd <= rdo ? 8'hff : d;
        @(posedge clk);
        {rd_n, wr_n} <= {~rdo, rdo};
        repeat (10) @(posedge clk);
        hrd = dw;
        {rd_n, wr_n} <= 2'h3;
        repeat (10) @(posedge clk);
        cs_n <= 1;
        hd <= 8'hff;
    endtask
    task summarize;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1;
        repeat (14) @(posedge clk);
        foreach (rows[i]) begin
            hbus(0, 0, rows[i][10:8], rows[i][7:0]);
            axr({3'h1, rows[i][10:8], 2'h0});
            chk("window", rows[i][7:0], rd);
            axr(8'h0c);
            chk("host_addr", rows[i][10:8], rd);
        end
        hbus(0, 1, 3'h0, 8'h3c);
        axr(8'h20);
        chk("deselected", 8'ha5, rd);
        hbus(1, 0, 3'h3, 8'h00);
        chk("host_read", 8'h5a, hrd);
        axr(8'h44);
        chk("unmapped_resp", 2'h2, rs);
        axr(8'h08);
        chk("straps", 3'h0, rd[3:1]);
        axw(8'h00, 32'h8);
        chk("irq_set", 1'b0, irq_n);
        axw(8'h00, 32'h0);
        chk("irq_clear", 1'b1, irq_n);
        axw(8'h04, 32'h1);
        chk("driver_on", 1'b0, drv);
        repeat (200) @(posedge clk);
        chk("driver_off", 1'b1, drv);
        axr(8'h08);
        chk("rx_seen", 1'b1, rd[5]);
        axw(8'h44, 32'h0);
        chk("unmapped_wr", 2'h2, rs);
        axw(8'h00, 32'h8);
        hrst_n <= 0;
        repeat (8) @(posedge clk);
        chk("hrst_irq", 1'b1, irq_n);
        axr(8'h08);
        chk("hrst_flag", 1'b1, rd[7]);
        hrst_n <= 1;
        tmg <= 0;
        hbus(0, 0, 3'h2, 8'h77);
        axr(8'h28);
        chk("fast_write", 8'h77, rd);
        axr(8'h08);
        chk("fast_flag", 1'b1, rd[2]);
        tmg <= 1;
        // Restart on the multiplexed bus: strap low, bit one open, address 5 latched
        rst_b <= 0;
        ha <= 3'h6;
        hd <= 8'h05;
        repeat (4) @(posedge clk);
        rst_b <= 1;
        repeat (14) @(posedge clk);
        ha <= 3'h2;
        repeat (6) @(posedge clk);
        hbus(0, 0, 3'h2, 8'h3c);
        axr(8'h34);
        chk("mux_write", 8'h3c, rd);
        axw(8'h00, 32'h4);
        hbus(1, 0, 3'h2, 8'h00);
        chk("read68", 8'h3c, hrd);
        summarize();
    end
endmodule // pin_port_tb
`default_nettype wire
